// ### core/cts_pkg.sv
// Shared constants and types for the core timer interrupt sequencer
package cts_pkg;
  localparam int DATA_W = 32;
  localparam int NUM_IRQ = 32;
  localparam int IDX_W = 5;
  localparam int VEC_SHIFT = 2;
  localparam logic [4:0] TMZH_BIT = 5'h04;
  localparam logic [4:0] TMZL_BIT = 5'h1c;
  localparam logic [4:0] ARITH_BIT = 5'h1d;
  localparam logic [4:0] IRQ2_BIT = 5'h08;
  localparam logic [4:0] IRQ1_BIT = 5'h09;
  localparam logic [4:0] IRQ0_BIT = 5'h0a;
  localparam logic [4:0] RUN_EN_BIT = 5'h05;
  localparam logic [4:0] GLOB_EN_BIT = 5'h0c;
  localparam logic [4:0] NEST_EN_BIT = 5'h0b;
  localparam logic [31:0] NONMASK = 32'h0000_0003;
  localparam logic [31:0] MODE_CONTROL_ONE_RST = 32'h0000_0000;
  localparam logic [31:0] MODE_CONTROL_TWO_RST = 32'h0000_0000;
  localparam logic [2:0] PIN_CYC = 3'h4;
  localparam logic [2:0] PIN_ONE = 3'h1;
  typedef enum logic [2:0] {
    CTS_REG_COUNT = 3'h0,
    CTS_REG_PERIOD = 3'h1,
    CTS_REG_MODE_CONTROL_ONE = 3'h2,
    CTS_REG_MODE_CONTROL_TWO = 3'h3,
    CTS_REG_LATCH = 3'h4,
    CTS_REG_MASK = 3'h5,
    CTS_REG_MASKP = 3'h6
  } cts_reg_sel_t;
  typedef struct packed {
    logic wr;
    logic rd;
    cts_reg_sel_t sel;
    logic [31:0] data;
  } cts_ureg_req_t;
  typedef struct packed {
    logic [31:0] astat;
    logic [31:0] mode_control_one;
  } cts_status_t;
  typedef enum logic [2:0] {
    CTS_S_RUN = 3'b001,
    CTS_S_BR1 = 3'b010,
    CTS_S_BR2 = 3'b100
  } cts_state_t;
endpackage : cts_pkg

// ### core/cts_sequencer.sv
// Core timer and interrupt response sequencer top level
//
// Overview of operation
// - Enabled timer decrements the countdown value every core clock.
// - At zero with timer enabled raise interrupt, expiry pin high four cycles.
// - Cycle after zero, countdown reloads from the reload period register.
// - Interval between timer interrupts equals period plus one cycles.
// - Mode control two bit 5 runs (1) or halts (0) the timer.
// - Enable and disable both take effect one cycle late.
// - Each expiry sets both a high and a low priority timer request.
// - Reads leave timer alone; countdown write beats reload and decrement.
// - Respond only if active, unmasked, globally enabled, nothing higher pending.
// - Three prioritised external inputs, each maskable, edge or level sensitive.
// - Vectors spaced four locations apart, each with own latch and mask bit.
// - Entry outputs vector, pushes return, pushes status for external/timer, clears latch, nests.
// - Latch bit of the routine in service is cleared every cycle until return.
// - Return branches to stack top, pops, pops status if pushed, clears pointer.
// - Return stack is empty after reset.
// - Forced latch write is recognised next cycle, then two branch cycles.
// - Response stages: one latch cycle, one recognition, two branch cycles.
// - One instruction completes; next two are aborted during vector fetch.
// - Arithmetic exception processing starts two cycles after the exception.
// - External pin requests have a three-cycle latency.
// - High priority timer request uses bit 4 and vector 0x10.
module cts_sequencer #(
  parameter int ADDR_W = 24,
  parameter int STACK_DEPTH = 30
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic ce,
  input wire cts_pkg::cts_ureg_req_t ureg_req,
  input wire logic [2:0] ext_irq_pins_n,
  input wire logic arith_exc,
  input wire logic [31:0] arith_status_x,
  input wire logic [ADDR_W-1:0] pc_in,
  input wire logic core_active,
  input wire logic hold_off,
  input wire logic return_from_interrupt,
  output logic [31:0] reg_rdata,
  output logic [ADDR_W-1:0] vector_addr,
  output logic vector_valid,
  output logic abort_fetch,
  output logic [ADDR_W-1:0] ret_addr,
  output logic ret_valid,
  output logic status_restore,
  output logic [31:0] arith_status_x_out,
  output logic timer_expired_pin
);
  localparam int PUSH_W = ADDR_W;

  if (ADDR_W < cts_pkg::IDX_W + cts_pkg::VEC_SHIFT + 1) begin : g_chk
    $error("address width too small for vector table");
  end

  // Lowest set bit is the highest priority; msb flags a hit
  function automatic logic [5:0] cts_first_set(input logic [31:0] v);
    logic [5:0] r;
    r = '0;
    for (int i = cts_pkg::NUM_IRQ - 1; i >= 0; i--) begin
      if (v[i]) r = {1'b1, 5'(i)};
    end
    return r;
  endfunction : cts_first_set

  function automatic logic cts_pushes_status(input logic [4:0] idx);
    return idx == cts_pkg::TMZH_BIT || idx == cts_pkg::TMZL_BIT ||
      idx == cts_pkg::IRQ2_BIT || idx == cts_pkg::IRQ1_BIT ||
      idx == cts_pkg::IRQ0_BIT;
  endfunction : cts_pushes_status

  cts_pkg::cts_state_t state_r;
  logic [31:0] mode_control_one_r;
  logic [31:0] mode_control_two_r;
  logic [31:0] latch_r;
  logic [31:0] latch_nxt;
  logic [31:0] mask_r;
  logic [31:0] maskp_r;
  logic [2:0] pin_samp_r;
  logic [2:0] pin_prev_r;
  logic [2:0] ext_hit;
  logic sticky_r;
  logic [4:0] take_idx_r;
  logic [31:0] hw_set;
  logic [31:0] block;
  logic [31:0] eligible;
  logic [5:0] pick;
  logic [5:0] inserv;
  logic take;
  logic do_rti;
  logic [31:0] t_count;
  logic [31:0] t_period;
  logic t_zero;
  logic t_pin;
  logic [ADDR_W-1:0] rs_top;
  logic rs_empty;
  cts_pkg::cts_status_t st_din;
  cts_pkg::cts_status_t st_top;
  logic st_push;
  logic st_pop;
  logic wr_cnt;
  logic wr_per;

  assign wr_cnt = ureg_req.wr && ureg_req.sel == cts_pkg::CTS_REG_COUNT;
  assign wr_per = ureg_req.wr && ureg_req.sel == cts_pkg::CTS_REG_PERIOD;

  cts_timer #(
    .W(cts_pkg::DATA_W)
  ) u_timer (
    .clock(clock),
    .rstn(rstn),
    .ce(ce),
    .run_en(mode_control_two_r[cts_pkg::RUN_EN_BIT]),
    .cnt_we(wr_cnt),
    .per_we(wr_per),
    .wdata(ureg_req.data),
    .count(t_count),
    .period(t_period),
    .zero_hit(t_zero),
    .pin(t_pin)
  );

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) timer_expired_pin <= 1'b0;
    else if (ce) timer_expired_pin <= t_pin;
  end

  // External pins: sample stage, then edge or level detect into latch
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pin_samp_r <= 3'h7;
      pin_prev_r <= 3'h7;
      sticky_r <= 1'b0;
    end else if (ce) begin
      pin_samp_r <= ext_irq_pins_n;
      pin_prev_r <= pin_samp_r;
      sticky_r <= arith_exc;
    end
  end

  for (genvar k = 0; k < 3; k++) begin : g_ext
    assign ext_hit[k] = mode_control_two_r[k] ? (pin_prev_r[k] && !pin_samp_r[k])
                                   : !pin_samp_r[k];
  end

  always_comb begin
    hw_set = '0;
    hw_set[cts_pkg::IRQ0_BIT] = ext_hit[0];
    hw_set[cts_pkg::IRQ1_BIT] = ext_hit[1];
    hw_set[cts_pkg::IRQ2_BIT] = ext_hit[2];
    hw_set[cts_pkg::TMZH_BIT] = t_zero;
    hw_set[cts_pkg::TMZL_BIT] = t_zero;
    hw_set[cts_pkg::ARITH_BIT] = sticky_r;
  end

  // Nesting limits blocking to equal and lower priority
  assign inserv = cts_first_set(maskp_r);
  always_comb begin
    if (!inserv[5]) block = '0;
    else if (mode_control_one_r[cts_pkg::NEST_EN_BIT]) block = ~((32'h1 << inserv[4:0]) - 32'h1);
    else block = '1;
  end

  assign eligible = latch_r & (mask_r | cts_pkg::NONMASK) & ~block;
  assign pick = cts_first_set(eligible);
  assign take = state_r == cts_pkg::CTS_S_RUN && pick[5] && core_active &&
                mode_control_one_r[cts_pkg::GLOB_EN_BIT] && !hold_off;
  assign do_rti = state_r == cts_pkg::CTS_S_RUN && !take &&
                  return_from_interrupt && inserv[5] && !rs_empty;

  // Software write, then hardware sets win, then in-service clear
  always_comb begin
    latch_nxt = latch_r;
    if (ureg_req.wr && ureg_req.sel == cts_pkg::CTS_REG_LATCH) begin
      latch_nxt = ureg_req.data;
    end
    latch_nxt = latch_nxt | hw_set;
    if (inserv[5]) latch_nxt[inserv[4:0]] = 1'b0;
    if (take) latch_nxt[pick[4:0]] = 1'b0;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) latch_r <= '0;
    else if (ce) latch_r <= latch_nxt;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mode_control_one_r <= cts_pkg::MODE_CONTROL_ONE_RST;
      mode_control_two_r <= cts_pkg::MODE_CONTROL_TWO_RST;
      mask_r <= '0;
    end else if (ce) begin
      if (ureg_req.wr && ureg_req.sel == cts_pkg::CTS_REG_MODE_CONTROL_TWO) mode_control_two_r <= ureg_req.data;
      if (ureg_req.wr && ureg_req.sel == cts_pkg::CTS_REG_MASK) mask_r <= ureg_req.data;
      if (do_rti && cts_pushes_status(inserv[4:0])) mode_control_one_r <= st_top.mode_control_one;
      else if (ureg_req.wr && ureg_req.sel == cts_pkg::CTS_REG_MODE_CONTROL_ONE) begin
        mode_control_one_r <= ureg_req.data;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) maskp_r <= '0;
    else if (ce) begin
      if (take) maskp_r[pick[4:0]] <= 1'b1;
      else if (do_rti) maskp_r[inserv[4:0]] <= 1'b0;
      else if (ureg_req.wr && ureg_req.sel == cts_pkg::CTS_REG_MASKP) begin
        maskp_r <= ureg_req.data;
      end
    end
  end

  // Register reads have no side effects
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) reg_rdata <= '0;
    else if (ce && ureg_req.rd) begin
      case (ureg_req.sel)
        cts_pkg::CTS_REG_COUNT: reg_rdata <= t_count;
        cts_pkg::CTS_REG_PERIOD: reg_rdata <= t_period;
        cts_pkg::CTS_REG_MODE_CONTROL_ONE: reg_rdata <= mode_control_one_r;
        cts_pkg::CTS_REG_MODE_CONTROL_TWO: reg_rdata <= mode_control_two_r;
        cts_pkg::CTS_REG_LATCH: reg_rdata <= latch_r;
        cts_pkg::CTS_REG_MASK: reg_rdata <= mask_r;
        cts_pkg::CTS_REG_MASKP: reg_rdata <= maskp_r;
        default: reg_rdata <= '0;
      endcase
    end
  end

  // Return and status stacks
  assign st_din = '{astat: arith_status_x, mode_control_one: mode_control_one_r};
  assign st_push = take && cts_pushes_status(pick[4:0]);
  assign st_pop = do_rti && cts_pushes_status(inserv[4:0]);

  cts_stack #(
    .W(PUSH_W),
    .DEPTH(STACK_DEPTH)
  ) u_ret_stack (
    .clock(clock),
    .rstn(rstn),
    .ce(ce),
    .push(take),
    .pop(do_rti),
    .din(pc_in),
    .top(rs_top),
    .empty(rs_empty)
  );

  cts_stack #(
    .W($bits(cts_pkg::cts_status_t)),
    .DEPTH(STACK_DEPTH)
  ) u_stat_stack (
    .clock(clock),
    .rstn(rstn),
    .ce(ce),
    .push(st_push),
    .pop(st_pop),
    .din(st_din),
    .top(st_top),
    .empty()
  );

  // Response sequencing: recognition in RUN, then two branch cycles
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_r <= cts_pkg::CTS_S_RUN;
      take_idx_r <= '0;
    end else if (ce) begin
      case (state_r)
        cts_pkg::CTS_S_RUN: begin
          if (take) begin
            state_r <= cts_pkg::CTS_S_BR1;
            take_idx_r <= pick[4:0];
          end
        end
        cts_pkg::CTS_S_BR1: state_r <= cts_pkg::CTS_S_BR2;
        cts_pkg::CTS_S_BR2: state_r <= cts_pkg::CTS_S_RUN;
        default: state_r <= cts_pkg::CTS_S_RUN;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      vector_addr <= '0;
      vector_valid <= 1'b0;
      abort_fetch <= 1'b0;
    end else if (ce) begin
      vector_valid <= take;
      if (take) begin
        vector_addr <= ADDR_W'(pick[4:0]) << cts_pkg::VEC_SHIFT;
      end
      abort_fetch <= take || state_r == cts_pkg::CTS_S_BR1;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ret_addr <= '0;
      ret_valid <= 1'b0;
      status_restore <= 1'b0;
      arith_status_x_out <= '0;
    end else if (ce) begin
      ret_valid <= do_rti;
      status_restore <= st_pop;
      if (do_rti) ret_addr <= rs_top;
      if (st_pop) arith_status_x_out <= st_top.astat;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn || !ce);

  sequence s_branch;
    vector_valid && abort_fetch ##1 !vector_valid && abort_fetch ##1 !abort_fetch;
  endsequence

  AST_BRANCH_TWO: assert property (take |=> s_branch)
    else $error("branch did not take two aborted cycles");
  AST_VEC_ADDR: assert property (take |=> vector_addr == ADDR_W'($past(pick[4:0])) * 4)
    else $error("vector address not four times index");
  AST_TMZH_VEC: assert property (take && pick[4:0] == cts_pkg::TMZH_BIT |=> vector_addr == 'h10)
    else $error("timer high vector wrong");
  AST_FORCE_RECOG: assert property (
    ureg_req.wr && ureg_req.sel == cts_pkg::CTS_REG_LATCH && ureg_req.data == 32'h10 &&
    mask_r[cts_pkg::TMZH_BIT] && maskp_r == '0 && mode_control_one_r[cts_pkg::GLOB_EN_BIT] &&
    core_active && !hold_off && state_r == cts_pkg::CTS_S_RUN && hw_set == '0
    ##1 core_active && !hold_off && !ureg_req.wr |-> take)
    else $error("forced request not recognised next cycle");
  AST_LATCH_CLR: assert property (inserv[5] |=> !latch_r[$past(inserv[4:0])])
    else $error("in-service latch bit not cleared");
  AST_NO_TAKE_MASKED: assert property (take |-> mask_r[pick[4:0]] ||
                                       cts_pkg::NONMASK[pick[4:0]])
    else $error("masked request taken");
  AST_RTI_POP: assert property (do_rti |=> ret_valid && ret_addr == $past(rs_top) &&
                                !maskp_r[$past(inserv[4:0])])
    else $error("return did not pop and clear pointer");
  AST_TIMER_BOTH: assert property (t_zero && !ureg_req.wr |=>
                                   (latch_r[cts_pkg::TMZH_BIT] || maskp_r[cts_pkg::TMZH_BIT]) &&
                                   (latch_r[cts_pkg::TMZL_BIT] || maskp_r[cts_pkg::TMZL_BIT]))
    else $error("timer expiry did not latch");
endmodule : cts_sequencer

// ### core/cts_stack.sv
// Small LIFO memory with registered top-of-stack read data
module cts_stack #(
  parameter int W = 32,
  parameter int DEPTH = 30
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic ce,
  input wire logic push,
  input wire logic pop,
  input wire logic [W-1:0] din,
  output logic [W-1:0] top,
  output logic empty
);
  localparam int PW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] P_ONE = PW'(1);
  localparam logic [PW-1:0] P_TWO = PW'(2);
  localparam logic [PW-1:0] P_FULL = PW'(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] sp_r;

  if (DEPTH < 2) begin : g_chk
    $error("cts_stack depth below two");
  end

  always_ff @(posedge clock) begin
    if (ce && push && sp_r != P_FULL) begin
      mem[sp_r] <= din;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sp_r <= '0;
      top <= '0;
      empty <= 1'b1;
    end else if (ce) begin
      if (push && sp_r != P_FULL) begin
        sp_r <= sp_r + P_ONE;
        top <= din;
        empty <= 1'b0;
      end else if (pop && sp_r != '0) begin
        sp_r <= sp_r - P_ONE;
        top <= (sp_r >= P_TWO) ? mem[sp_r - P_TWO] : '0;
        empty <= (sp_r == P_ONE);
      end
    end
  end
endmodule : cts_stack

// ### core/cts_timer.sv
// Interval down-counter with reload and expiry pin stretch
module cts_timer #(
  parameter int W = 32
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic ce,
  input wire logic run_en,
  input wire logic cnt_we,
  input wire logic per_we,
  input wire logic [W-1:0] wdata,
  output logic [W-1:0] count,
  output logic [W-1:0] period,
  output logic zero_hit,
  output logic pin
);
  logic en_d_r;
  logic [2:0] pin_cnt_r;

  if (W < 2) begin : g_chk
    $error("cts_timer width too small");
  end

  // Enable acts one cycle late in both directions
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) en_d_r <= 1'b0;
    else if (ce) en_d_r <= run_en;
  end

  assign zero_hit = en_d_r && count == '0 && !cnt_we;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      count <= '0;
      period <= '0;
    end else if (ce) begin
      if (per_we) period <= wdata;
      if (cnt_we) count <= wdata;
      else if (en_d_r && count == '0) count <= period;
      else if (en_d_r) count <= count - W'(1);
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pin_cnt_r <= '0;
      pin <= 1'b0;
    end else if (ce) begin
      if (zero_hit) pin_cnt_r <= cts_pkg::PIN_CYC;
      else if (pin_cnt_r != '0) pin_cnt_r <= pin_cnt_r - cts_pkg::PIN_ONE;
      pin <= zero_hit || pin_cnt_r > cts_pkg::PIN_ONE;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn || !ce);

  sequence s_pin_four;
    pin [*4] ##1 !pin;
  endsequence

  AST_TMR_PIN4: assert property (zero_hit && pin_cnt_r == '0 |=> s_pin_four)
    else $error("expiry pin not high for four cycles");
  AST_TMR_DEC: assert property (en_d_r && !cnt_we && count != '0 |=> count == $past(count) - W'(1))
    else $error("count did not decrement");
  AST_TMR_RELOAD: assert property (zero_hit && !per_we |=> count == $past(period))
    else $error("count not reloaded after zero");
  AST_TMR_WR: assert property (cnt_we |=> count == $past(wdata))
    else $error("count write lost priority");
  AST_TMR_START: assert property ($rose(run_en) && !cnt_we |=> count == $past(count))
    else $error("count moved in enable cycle");
endmodule : cts_timer

// ### testbench/cts_pipe_model.sv
// Pipeline and external interrupt source model facing the sequencer
module cts_pipe_model #(
  parameter int ADDR_W = 24
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic abort_fetch,
  input wire logic rti_req,
  input wire logic [2:0] pin_req,
  output logic [ADDR_W-1:0] pc_in,
  output logic core_active,
  output logic hold_off,
  output logic return_from_interrupt,
  output logic [2:0] ext_irq_pins_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // Always executing, never holding off recognition
  assign core_active = rstn;
  assign hold_off = 1'b0;
  // Program counter stalls while fetches are aborted
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pc_in <= ADDR_W'(16'h0100);
    end else if (!abort_fetch) begin
      pc_in <= pc_in + 1'b1;
    end
  end
  // Return strobe and pins; released pins are driven high
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      return_from_interrupt <= 1'b0;
      ext_irq_pins_n <= 3'h7;
    end else begin
      return_from_interrupt <= rti_req;
      ext_irq_pins_n <= ~pin_req;
    end
  end
endmodule : cts_pipe_model

// ### testbench/cts_sequencer_tb.sv
// Self-checking bench for the core timer interrupt sequencer
module cts_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int AW = 24;
  localparam logic [31:0] ASTAT_V = 32'h0000_00a5;
  localparam logic [31:0] PER = 32'h0000_0005;
  logic clock, rstn, rti_req, core_active, hold_off, return_from_interrupt, arith_exc;
  cts_pkg::cts_ureg_req_t ureg_req;
  logic [2:0] pin_req, ext_irq_pins_n;
  logic [AW-1:0] pc_in, vector_addr, ret_addr, exp_ret;
  logic [31:0] reg_rdata, arith_status_x_out, rd;
  logic vector_valid, abort_fetch, ret_valid, status_restore, timer_expired_pin;
  int num_errors, cmp_count, n, m;

  cts_sequencer #(.ADDR_W(AW), .STACK_DEPTH(30)) uut (
    .clock(clock), .rstn(rstn), .ce(1'b1), .ureg_req(ureg_req),
    .ext_irq_pins_n(ext_irq_pins_n), .arith_exc(arith_exc), .arith_status_x(ASTAT_V),
    .pc_in(pc_in), .core_active(core_active), .hold_off(hold_off),
    .return_from_interrupt(return_from_interrupt), .reg_rdata(reg_rdata),
    .vector_addr(vector_addr), .vector_valid(vector_valid), .abort_fetch(abort_fetch),
    .ret_addr(ret_addr), .ret_valid(ret_valid), .status_restore(status_restore),
    .arith_status_x_out(arith_status_x_out), .timer_expired_pin(timer_expired_pin)
  );
  cts_pipe_model #(.ADDR_W(AW)) partner (
    .clock(clock), .rstn(rstn), .abort_fetch(abort_fetch), .rti_req(rti_req),
    .pin_req(pin_req), .pc_in(pc_in), .core_active(core_active), .hold_off(hold_off),
    .return_from_interrupt(return_from_interrupt), .ext_irq_pins_n(ext_irq_pins_n)
  );

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk_val
  task automatic chk_cyc(input int got, input int exp, input string msg);
    cmp_count++;
    if (got != exp) begin
      num_errors++;
      $display("ERROR %0t %s got %0d exp %0d", $time, msg, got, exp);
    end
  endtask : chk_cyc
  task automatic reg_wr(input cts_pkg::cts_reg_sel_t s, input logic [31:0] d);
    @(posedge clock);
    ureg_req <= '{wr: 1'b1, rd: 1'b0, sel: s, data: d};
    @(posedge clock);
    ureg_req <= '0;
  endtask : reg_wr
  task automatic reg_rd(input cts_pkg::cts_reg_sel_t s, output logic [31:0] d);
    @(posedge clock);
    ureg_req <= '{wr: 1'b0, rd: 1'b1, sel: s, data: 32'h0000_0000};
    @(posedge clock);
    ureg_req <= '0;
    @(posedge clock);
    #1 d = reg_rdata;
  endtask : reg_rd
  task automatic rti_pulse;
    @(posedge clock);
    rti_req <= 1'b1;
    @(posedge clock);
    rti_req <= 1'b0;
  endtask : rti_pulse
  // Edges until vector_valid shows, bounded
  task automatic wait_vec(output int k);
    k = 0;
    do begin
      @(posedge clock);
      #1 k++;
    end while (vector_valid !== 1'b1 && k < 10);
  endtask : wait_vec
  task automatic check_return(input logic [31:0] exp_addr);
    rti_pulse();
    n = 0;
    do begin
      @(posedge clock);
      #1 n++;
    end while (ret_valid !== 1'b1 && n < 6);
    chk_val(32'(ret_addr), exp_addr, "return address");
    chk_val(32'(status_restore), 32'h1, "status pop");
    chk_val(arith_status_x_out, ASTAT_V, "popped status");
    reg_rd(cts_pkg::CTS_REG_MASKP, rd);
    chk_val(rd, 32'h0, "nesting pointer after return");
  endtask : check_return

  task automatic t_empty_return;
    rti_pulse();
    m = 0;
    repeat (5) begin
      @(posedge clock);
      #1 m = m + int'(ret_valid === 1'b1);
    end
    chk_cyc(m, 0, "return with empty stack");
  endtask : t_empty_return
  task automatic t_regs;
    reg_wr(cts_pkg::CTS_REG_COUNT, 32'h1234_5678);
    reg_wr(cts_pkg::CTS_REG_PERIOD, 32'hfedc_ba98);
    reg_wr(cts_pkg::cts_reg_sel_t'(3'h7), 32'hffff_ffff);
    reg_rd(cts_pkg::CTS_REG_COUNT, rd);
    chk_val(rd, 32'h1234_5678, "countdown readback");
    repeat (4) @(posedge clock);
    reg_rd(cts_pkg::CTS_REG_COUNT, rd);
    chk_val(rd, 32'h1234_5678, "halted countdown");
    reg_rd(cts_pkg::CTS_REG_PERIOD, rd);
    chk_val(rd, 32'hfedc_ba98, "period readback");
    reg_rd(cts_pkg::cts_reg_sel_t'(3'h7), rd);
    chk_val(rd, 32'h0, "unmapped read");
  endtask : t_regs
  task automatic t_timer;
    reg_wr(cts_pkg::CTS_REG_COUNT, 32'h0000_0003);
    reg_wr(cts_pkg::CTS_REG_PERIOD, PER);
    reg_wr(cts_pkg::CTS_REG_MODE_CONTROL_TWO, 32'h0000_0020);
    n = 0;
    while (timer_expired_pin !== 1'b1 && n < 20) begin
      @(posedge clock);
      #1 n++;
    end
    n = 0;
    while (timer_expired_pin === 1'b1 && n < 10) begin
      @(posedge clock);
      #1 n++;
    end
    chk_cyc(n, 4, "expiry pin width");
    m = 0;
    while (timer_expired_pin !== 1'b1 && m < 20) begin
      @(posedge clock);
      #1 m++;
    end
    chk_cyc(n + m, int'(PER) + 1, "expiry interval");
    reg_rd(cts_pkg::CTS_REG_LATCH, rd);
    chk_val(rd & 32'h1000_0010, 32'h1000_0010, "both timer requests");
    reg_wr(cts_pkg::CTS_REG_MODE_CONTROL_TWO, 32'h0000_0000);
    repeat (8) @(posedge clock);
    reg_wr(cts_pkg::CTS_REG_LATCH, 32'h0000_0000);
  endtask : t_timer
  task automatic t_forced;
    reg_wr(cts_pkg::CTS_REG_MODE_CONTROL_ONE, 32'h0000_1000);
    reg_wr(cts_pkg::CTS_REG_MASK, 32'h0000_0010);
    reg_wr(cts_pkg::CTS_REG_LATCH, 32'h0000_0010);
    #1 exp_ret = pc_in;
    wait_vec(n);
    chk_cyc(n, 1, "forced request latency");
    chk_val(32'(vector_addr), 32'h0000_0010, "timer high vector");
    chk_val(32'(abort_fetch), 32'h1, "first abort");
    @(posedge clock);
    #1 chk_val({30'h0, vector_valid, abort_fetch}, 32'h1, "second branch cycle");
    @(posedge clock);
    #1 chk_val(32'(abort_fetch), 32'h0, "abort length");
    reg_rd(cts_pkg::CTS_REG_MASKP, rd);
    chk_val(rd, 32'h0000_0010, "nesting pointer set");
    reg_wr(cts_pkg::CTS_REG_LATCH, 32'h0000_0010);
    reg_rd(cts_pkg::CTS_REG_LATCH, rd);
    chk_val(rd, 32'h0, "in-service latch cleared");
    check_return(32'(exp_ret));
  endtask : t_forced
  task automatic t_arith;
    reg_wr(cts_pkg::CTS_REG_MASK, 32'h2000_0000);
    @(posedge clock);
    arith_exc <= 1'b1;
    @(posedge clock);
    arith_exc <= 1'b0;
    wait_vec(n);
    chk_cyc(n, 2, "exception latency");
    chk_val(32'(vector_addr), 32'h0000_0074, "exception vector");
    exp_ret = pc_in - AW'(1);
    rti_pulse();
    @(posedge clock);
    #1 chk_val({30'h0, ret_valid, status_restore}, 32'h2, "return without status");
    chk_val(32'(ret_addr), 32'(exp_ret), "exception return address");
  endtask : t_arith
  task automatic t_ext;
    @(posedge clock);
    pin_req <= 3'h1;
    m = 0;
    repeat (6) begin
      @(posedge clock);
      #1 m = m + int'(vector_valid === 1'b1);
    end
    chk_cyc(m, 0, "masked pin request");
    reg_rd(cts_pkg::CTS_REG_LATCH, rd);
    chk_val(rd & 32'h0000_0400, 32'h0000_0400, "pin request latched");
    reg_wr(cts_pkg::CTS_REG_MASK, 32'h0000_0400);
    wait_vec(n);
    chk_val(32'(vector_addr), 32'h0000_0028, "pin zero vector");
    exp_ret = pc_in - AW'(1);
    @(posedge clock);
    pin_req <= 3'h0;
    repeat (3) @(posedge clock);
    check_return(32'(exp_ret));
    reg_wr(cts_pkg::CTS_REG_MODE_CONTROL_TWO, 32'h0000_0001);
    @(posedge clock);
    pin_req <= 3'h1;
    wait_vec(n);
    chk_cyc(n, 4, "edge pin latency");
    @(posedge clock);
    pin_req <= 3'h0;
  endtask : t_ext

  task automatic close_out;
    $display("errors %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out

  initial begin
    #(100 * 5000);
    num_errors++;
    close_out();
  end
  initial begin
    rstn = 1'b0;
    ureg_req = '0;
    pin_req = 3'h0;
    rti_req = 1'b0;
    arith_exc = 1'b0;
    num_errors = 0;
    cmp_count = 0;
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    t_empty_return();
    t_regs();
    t_timer();
    t_forced();
    t_arith();
    t_ext();
    close_out();
  end
endmodule : cts_sequencer_tb
